// file: logic/fifo_port_pkg.sv
// Shared constants and types for the byte-wide parallel FIFO port.
// Assumes one system clock, clk_sys, at 20 MHz on both ends.
package fifo_port_pkg;

  // System clock period and the printed link times in nanoseconds.
  localparam int CLK_PERIOD_NS = 50;
  localparam int FLAG_HOLD_NS = 100;
  localparam int STROBE_MIN_NS = 30;

  // Least time in ns rounded up to whole clk_sys cycles, never below one.
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int FLAG_HOLD_CYC = ns_to_cycles(FLAG_HOLD_NS);
  localparam int STROBE_MIN_CYC = ns_to_cycles(STROBE_MIN_NS);

  // Structure defaults.
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CLKOUT_HALF = 4;
  localparam int HOST_STROBE_CYC = 8;
  localparam int HOST_GAP_CYC = 8;
  localparam int CNT_W = 4;

  // Idle levels: strobes and flags rest high, the bus floats high.
  localparam logic [7:0] BUS_IDLE = 8'hff;
  localparam logic [2:0] STROBES_IDLE = 3'h7;
  // Receive flag, transmit flag and link clock as the host sees them idle.
  localparam logic [2:0] FLAGS_IDLE = 3'h6;

  // Host sequencer states, Gray coded along idle-strobe-gap.
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_READ = 2'b01,
    H_GAP = 2'b11,
    H_WRITE = 2'b10
  } host_state_t;

endpackage

// file: logic/fifo_port_if.sv
// Pin bundle of the parallel FIFO port, one modport for each end.
// Resolves the shared data bus from the two output enables; an
// undriven bus reads as the pulled-up idle value.
`timescale 1ns/1ps
interface fifo_port_if;
  import fifo_port_pkg::*;

  logic rdN;
  logic wrN;
  logic oeN;
  logic rxfN;
  logic txeN;
  logic clkOut;
  logic [7:0] devData;
  logic devOe;
  logic [7:0] hostData;
  logic hostOe;
  wire [7:0] bus;

  // Device wins only if both drive, which a legal exchange never does.
  assign bus = devOe ? devData : (hostOe ? hostData : BUS_IDLE);

  modport device (
    input rdN, wrN, oeN, bus,
    output rxfN, txeN, clkOut, devData, devOe
  );

  modport host (
    input rxfN, txeN, clkOut, bus,
    output rdN, wrN, oeN, hostData, hostOe
  );
endinterface

// file: logic/fifo_port_device.sv
// Device end of the parallel FIFO port, with its own byte buffer module.
// Assumes the pins of fifo_port_if arrive asynchronously and that the
// user side drains and fills the buffers on clk_sys.
//
// Contract
// R1 - Async: byte bus, two strobes, two flags.
// R2 - Receive flag low only with byte waiting.
// R3 - Transmit flag low only with free space.
// R4 - Read strobe low drives byte; fall advances.
// R5 - Write strobe fall captures bus byte.
// R6 - Async bus enable follows the read strobe.
// R7 - Read strobe rising raises receive flag.
// R8 - Write strobe falling raises transmit flag.
// R9 - Receive flag high 100 ns after read.
// R10 - Transmit flag high 100 ns after write.
// R11 - Host holds strobes low 30 ns minimum.
// R12 - Host reads only after receive flag low.
// R13 - Sync mode adds output enable, clock out.
// R14 - Sync: one byte per clock out.
// R15 - Host lowers output enable before reading.
// R16 - Sync read burst keeps read strobe low.
// R17 - Sync receive flag low while bytes remain.
// R18 - Sync write burst; flag low while space.
// R19 - Sync flags and sampling on clock out.
// R20 - Mode is static, chosen before transfers.
`timescale 1ns/1ps

// First-word-fall-through buffer with valid and ready on both sides.
module fifo_port_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("Buffer depth must be a power of two, at least two.");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;

  // Full and empty come straight from the count, so both are exact.
  assign inReady = (count_q != (AW + 1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign level = count_q;

  // Pointers and count; a push and pop together leave the count alone.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + AW'(push);
      rdPtr_q <= rdPtr_q + AW'(pop);
      count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // Storage needs no reset; nothing reads a slot before it is written.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule

module fifo_port_device
  import fifo_port_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int CLK_HALF = CLKOUT_HALF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic syncMode,
  input wire logic rxInValid,
  output logic rxInReady,
  input wire logic [WIDTH-1:0] rxInData,
  output logic txOutValid,
  input wire logic txOutReady,
  output logic [WIDTH-1:0] txOutData,
  fifo_port_if.device link
);
  localparam int LW = $clog2(DEPTH) + 1;
  localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);
  localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(FLAG_HOLD_CYC);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(CLK_HALF - 1);

  // The host needs two sync stages plus a cycle to answer a clock edge.
  initial begin
    if (WIDTH != 8) begin
      $error("The link bus is one byte wide.");
    end
    if (CLK_HALF < 4 || CLK_HALF > 15) begin
      $error("Clock out half period must be 4 to 15 cycles.");
    end
  end

  // Two-flop synchronisers for the strobes, output enable and bus.
  logic [10:0] pinS1_q;
  logic [10:0] pinS2_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pinS1_q <= {STROBES_IDLE, BUS_IDLE};
      pinS2_q <= {STROBES_IDLE, BUS_IDLE};
    end else begin
      pinS1_q <= {link.oeN, link.wrN, link.rdN, link.bus};
      pinS2_q <= pinS1_q;
    end
  end

  wire [7:0] busS = pinS2_q[7:0];
  wire rdS = pinS2_q[8];
  wire wrS = pinS2_q[9];
  wire oeS = pinS2_q[10];

  // Previous strobe levels, for edge detection past the synchroniser.
  logic rdPrev_q;
  logic wrPrev_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdPrev_q <= 1'b1;
      wrPrev_q <= 1'b1;
    end else begin
      rdPrev_q <= rdS;
      wrPrev_q <= wrS;
    end
  end

  wire rdFall = rdPrev_q & ~rdS;
  wire rdRise = ~rdPrev_q & rdS;
  wire wrFall = wrPrev_q & ~wrS;
  wire wrRise = ~wrPrev_q & wrS;

  // Clock out divider; it stands low outside synchronous mode.
  logic [CNT_W-1:0] div_q;
  logic clkOut_q;
  wire divEnd = (div_q == HALF_LAST);
  wire tick = syncMode & divEnd & ~clkOut_q; // [R19]
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_q <= '0;
      clkOut_q <= 1'b0;
    end else if (!syncMode) begin
      div_q <= '0;
      clkOut_q <= 1'b0;
    end else begin
      div_q <= divEnd ? '0 : div_q + 1'b1;
      clkOut_q <= clkOut_q ^ divEnd; // [R13]
    end
  end

  // Receive and transmit buffers between the user side and the pins.
  logic [WIDTH-1:0] rxHead;
  logic [LW-1:0] rxLevel;
  logic [LW-1:0] txLevel;
  logic txInReady;
  logic rxPop;
  logic txPush;

  fifo_port_buffer #(.WIDTH(WIDTH), .DEPTH(DEPTH)) rxBuf (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .inValid(rxInValid),
    .inReady(rxInReady),
    .inData(rxInData),
    .outValid(),
    .outReady(rxPop),
    .outData(rxHead),
    .level(rxLevel)
  );

  fifo_port_buffer #(.WIDTH(WIDTH), .DEPTH(DEPTH)) txBuf (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .inValid(txPush),
    .inReady(txInReady),
    .inData(busS),
    .outValid(txOutValid),
    .outReady(txOutReady),
    .outData(txOutData),
    .level(txLevel)
  );

  logic rxfN_q;
  logic txeN_q;
  logic [CNT_W-1:0] rxHold_q;
  logic [CNT_W-1:0] txHold_q;
  logic [7:0] data_q;

  // Transfer decode. The mode input is read live, so it must stay put
  // while any strobe is low; a change mid-transfer is not recovered.
  wire rxAvail = (rxLevel != '0);
  wire asyncPop = ~syncMode & rdFall & rxAvail; // [R4] [R20]
  wire syncPop = tick & ~rdS & ~oeS & ~rxfN_q; // [R14] [R16]
  wire asyncPush = ~syncMode & wrFall & txInReady; // [R5]
  wire syncPush = tick & ~wrS & ~txeN_q; // [R14] [R18]
  assign rxPop = asyncPop | syncPop;
  assign txPush = asyncPush | syncPush;

  // What is left once this cycle's transfer has gone through.
  wire rxLeft = rxPop ? (rxLevel > LW'(1)) : rxAvail;
  wire txRoom = txPush ? (txLevel < FULL_LEVEL - LW'(1)) : (txLevel != FULL_LEVEL);

  // Receive flag next value.
  logic rxfN_d;
  assign rxfN_d = syncMode ? (tick ? ~rxLeft : rxfN_q) : // [R17] [R19]
                  rdRise ? 1'b1 : // [R7]
                  ~rdS ? rxfN_q :
                  (rxHold_q != '0) ? 1'b1 : // [R9]
                  ~rxAvail; // [R2]

  // Transmit flag next value; a falling write strobe raises it in async mode.
  logic txeN_d;
  assign txeN_d = syncMode ? (tick ? ~txRoom : txeN_q) : // [R18] [R19]
                  ~wrS ? 1'b1 : // [R8]
                  wrRise ? 1'b1 : // [R10] Covers the cycle before the hold loads.
                  (txHold_q != '0) ? 1'b1 : // [R10]
                  ~txRoom; // [R3]

  // Flags and hold timers. The hold starts when the strobe rises, so
  // the flag stays high for the hold plus the edge-detect cycle.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxfN_q <= 1'b1;
      txeN_q <= 1'b1;
      rxHold_q <= '0;
      txHold_q <= '0;
    end else begin
      rxfN_q <= rxfN_d;
      txeN_q <= txeN_d;
      rxHold_q <= (rdRise & ~syncMode) ? HOLD_LOAD : // [R9]
                  (rxHold_q != '0) ? rxHold_q - 1'b1 : rxHold_q;
      txHold_q <= (wrRise & ~syncMode) ? HOLD_LOAD : // [R10]
                  (txHold_q != '0) ? txHold_q - 1'b1 : txHold_q;
    end
  end

  // Read byte register, loaded from the head as the byte is taken.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      data_q <= BUS_IDLE;
    end else if (rxPop) begin
      data_q <= rxHead; // [R4]
    end
  end

  // Bus enable: the read strobe in async mode, held off one cycle so
  // the fresh byte is in data_q before the bus turns; the host's output
  // enable in sync mode.
  assign link.devOe = syncMode ? ~oeS : (~rdS & ~rdPrev_q); // [R6] [R13] [R1]
  assign link.devData = data_q;
  assign link.rxfN = rxfN_q; // [R1]
  assign link.txeN = txeN_q; // [R1]
  assign link.clkOut = clkOut_q;
endmodule

// file: logic/fifo_port_host.sv
// Host end of the parallel FIFO port: issues reads and writes.
// Assumes the device end over fifo_port_if; its flags, clock out and
// the bus arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
module fifo_port_host
  import fifo_port_pkg::*;
#(
  parameter int STROBE_CYC = HOST_STROBE_CYC,
  parameter int GAP_CYC = HOST_GAP_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic syncMode,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [7:0] wrData,
  input wire logic rdEnable,
  output logic rdValid,
  output logic [7:0] rdData,
  fifo_port_if.host link
);
  localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYC);
  localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(GAP_CYC);

  // The strobe must outlast the device's sync and turn-round delay.
  initial begin
    if (STROBE_CYC < STROBE_MIN_CYC || STROBE_CYC < 6 || STROBE_CYC > 15) begin
      $error("Strobe length must be 6 to 15 cycles.");
    end
    if (GAP_CYC < 6 || GAP_CYC > 15) begin
      $error("Gap length must be 6 to 15 cycles.");
    end
  end

  // Two-flop synchronisers for the flags, clock out and bus.
  logic [10:0] pinS1_q;
  logic [10:0] pinS2_q;
  logic clkPrev_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pinS1_q <= {FLAGS_IDLE, BUS_IDLE};
      pinS2_q <= {FLAGS_IDLE, BUS_IDLE};
      clkPrev_q <= 1'b0;
    end else begin
      pinS1_q <= {link.rxfN, link.txeN, link.clkOut, link.bus};
      pinS2_q <= pinS1_q;
      clkPrev_q <= pinS2_q[8];
    end
  end

  wire [7:0] busS = pinS2_q[7:0];
  wire clkS = pinS2_q[8];
  wire txeS = pinS2_q[9];
  wire rxfS = pinS2_q[10];
  wire hTick = syncMode & clkS & ~clkPrev_q;

  host_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic rdN_q;
  logic wrN_q;
  logic oeN_q;
  logic hostOe_q;
  logic [7:0] hostData_q;
  logic rdPend_q;
  logic rdValid_q;
  logic [7:0] rdData_q;

  // Decisions. A read is started only on a low receive flag, and a
  // write only on a low transmit flag; reads take priority.
  wire wantRd = rdEnable & ~rxfS; // [R2] [R12]
  wire asyncIdle = ~syncMode & (state_q == H_IDLE);
  wire asyncRd = asyncIdle & wantRd;
  wire asyncWr = asyncIdle & ~wantRd & wrValid & ~txeS; // [R3]
  // Sync writes wait for a tick with the output enable already high,
  // so the two ends never drive the bus together.
  wire syncWr = hTick & ~wantRd & wrValid & ~txeS & oeN_q; // [R3] [R14]
  assign wrReady = asyncWr | syncWr;

  // Sequencer and pins.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= H_IDLE;
      cnt_q <= '0;
      rdN_q <= 1'b1;
      wrN_q <= 1'b1;
      oeN_q <= 1'b1;
      hostOe_q <= 1'b0;
      hostData_q <= BUS_IDLE;
      rdPend_q <= 1'b0;
      rdValid_q <= 1'b0;
      rdData_q <= BUS_IDLE;
    end else begin
      rdValid_q <= 1'b0;
      if (syncMode) begin
        state_q <= H_IDLE;
        if (hTick) begin
          // A byte popped on the last device edge is on the bus now.
          rdValid_q <= rdPend_q; // [R14]
          if (rdPend_q) begin
            rdData_q <= busS;
          end
          if (wantRd) begin
            oeN_q <= 1'b0; // [R15]
            rdN_q <= oeN_q; // [R15] [R16]
            wrN_q <= 1'b1;
            hostOe_q <= 1'b0;
            rdPend_q <= ~oeN_q;
          end else if (syncWr) begin
            wrN_q <= 1'b0; // [R18]
            hostData_q <= wrData;
            hostOe_q <= 1'b1;
            rdN_q <= 1'b1;
            rdPend_q <= 1'b0;
          end else begin
            rdN_q <= 1'b1;
            wrN_q <= 1'b1;
            oeN_q <= 1'b1;
            hostOe_q <= 1'b0;
            rdPend_q <= 1'b0;
          end
        end
      end else begin
        oeN_q <= 1'b1;
        rdPend_q <= 1'b0;
        unique case (state_q)
          H_IDLE: begin
            cnt_q <= STROBE_LOAD;
            if (asyncRd) begin
              rdN_q <= 1'b0; // [R12]
              state_q <= H_READ;
            end else if (asyncWr) begin
              // Data goes out a cycle ahead of the strobe for setup.
              hostData_q <= wrData;
              hostOe_q <= 1'b1;
              state_q <= H_WRITE;
            end
          end
          H_READ: begin
            if (cnt_q != '0) begin
              cnt_q <= cnt_q - 1'b1; // [R11]
            end else begin
              rdN_q <= 1'b1; // [R2]
              rdData_q <= busS;
              rdValid_q <= 1'b1;
              cnt_q <= GAP_LOAD;
              state_q <= H_GAP;
            end
          end
          H_WRITE: begin
            if (wrN_q) begin
              wrN_q <= 1'b0;
            end else if (cnt_q != '0) begin
              cnt_q <= cnt_q - 1'b1; // [R11]
            end else begin
              wrN_q <= 1'b1;
              cnt_q <= GAP_LOAD;
              state_q <= H_GAP;
            end
          end
          H_GAP: begin
            // Waits out the device's flag hold before looking again.
            if (cnt_q != '0) begin
              cnt_q <= cnt_q - 1'b1;
            end else begin
              hostOe_q <= 1'b0;
              state_q <= H_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign link.rdN = rdN_q;
  assign link.wrN = wrN_q;
  assign link.oeN = oeN_q;
  assign link.hostOe = hostOe_q;
  assign link.hostData = hostData_q;
  assign rdValid = rdValid_q;
  assign rdData = rdData_q;
endmodule

// file: verif/parallel_fifo_host_port_props.sv
// Concurrent checks on the pins that join the two port ends.
// Assumes one clk_sys domain and a syncMode held still outside reset.
`timescale 1ns/1ps
module parallel_fifo_host_port_props (
  input logic clk_sys,
  input logic resetn,
  input logic syncMode,
  input logic rdN,
  input logic wrN,
  input logic oeN,
  input logic rxfN,
  input logic txeN,
  input logic clkOut,
  input logic devOe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Strobe-paced mode has no link clock, so it must rest low.
  a_async_clk_low: assert property (!syncMode |-> !clkOut)
    else $error("link clock moved in async mode");
  // A host read may only start while a byte is flagged.
  a_read_after_flag: assert property (!syncMode && $fell(rdN) |-> !rxfN)
    else $error("read strobe fell with receive flag high");
  // The bus drive follows the read strobe; sync latency allows a few cycles.
  a_bus_follows_read: assert property (!syncMode && $fell(rdN) |-> ##[2:5] devOe)
    else $error("device did not drive bus on read");
  a_async_bus_idle: assert property ((!syncMode && rdN) [*5] |-> !devOe)
    else $error("device drove bus without read strobe");
  // Flags go inactive after each strobe and stay so for the hold time.
  a_read_drops_flag: assert property (!syncMode && $rose(rdN) |-> ##[1:4] rxfN)
    else $error("receive flag not raised after read");
  a_rx_flag_hold: assert property (!syncMode && $rose(rxfN) |-> rxfN [*2])
    else $error("receive flag hold too short");
  a_write_drops_flag: assert property (!syncMode && $fell(wrN) |-> ##[1:4] txeN)
    else $error("transmit flag not raised after write");
  a_tx_flag_hold: assert property (!syncMode && $rose(txeN) |-> txeN [*2])
    else $error("transmit flag hold too short");
  // The flag must not dip low in the gap between the strobe rising and the hold starting.
  a_tx_hold_after_write: assert property (!syncMode && $rose(wrN) |-> txeN [*5])
    else $error("transmit flag fell too soon after write");
  // Link clock shape follows the default half period of four cycles.
  a_sync_clk_shape: assert property (syncMode && $rose(clkOut) |->
    clkOut [*4] ##1 !clkOut [*4])
    else $error("link clock period wrong");
  // Flags may only move at the tick where the link clock rises.
  a_flags_on_tick: assert property (syncMode && ($changed(rxfN) || $changed(txeN))
    |-> $rose(clkOut))
    else $error("flag moved between link clock ticks");
  a_sync_oe_gate: assert property ((syncMode && oeN) [*4] |-> !devOe)
    else $error("device drove bus with output enable high");

  // Main traffic kinds seen at least once.
  c_async_read: cover property (!syncMode && $rose(rxfN));
  c_async_write: cover property (!syncMode && $rose(txeN));
  c_sync_read: cover property (syncMode && !rdN && !oeN && $rose(clkOut));
endmodule

// file: verif/parallel_fifo_host_port_tb_top.sv
// Self-checking bench joining the host and device ends over one link.
// Assumes the package and design files under logic/ compile first.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failCount++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module parallel_fifo_host_port_tb_top;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic syncMode = 1'b0;
  logic rxInValid = 1'b0;
  logic [7:0] rxInData = 8'h00;
  logic txOutReady = 1'b0;
  logic wrValid = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic rdEnable = 1'b0;
  logic rxInReady;
  logic txOutValid;
  logic [7:0] txOutData;
  logic wrReady;
  logic rdValid;
  logic [7:0] rdData;
  logic [7:0] rdQ[$];
  logic [7:0] txQ[$];
  int failCount = 0;
  int checked = 0;
  int cycles = 0;

  fifo_port_if lnk ();
  fifo_port_device fifo_port_device_i (.clk_sys(clk_sys), .resetn(resetn),
    .syncMode(syncMode), .rxInValid(rxInValid), .rxInReady(rxInReady),
    .rxInData(rxInData), .txOutValid(txOutValid), .txOutReady(txOutReady),
    .txOutData(txOutData), .link(lnk));
  fifo_port_host fifo_port_host_i (.clk_sys(clk_sys), .resetn(resetn),
    .syncMode(syncMode), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
    .rdEnable(rdEnable), .rdValid(rdValid), .rdData(rdData), .link(lnk));
  parallel_fifo_host_port_props parallel_fifo_host_port_props_i (.clk_sys(clk_sys),
    .resetn(resetn), .syncMode(syncMode), .rdN(lnk.rdN), .wrN(lnk.wrN),
    .oeN(lnk.oeN), .rxfN(lnk.rxfN), .txeN(lnk.txeN), .clkOut(lnk.clkOut),
    .devOe(lnk.devOe));

  // Free-running system clock at 50 ns.
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Collect bytes leaving either end; the ceiling is far above the
  // several hundred cycles the scenarios need, so only a hang reaches it.
  always @(posedge clk_sys) begin
    if (rdValid === 1'b1) rdQ.push_back(rdData);
    if (txOutValid === 1'b1 && txOutReady === 1'b1) txQ.push_back(txOutData);
    cycles++;
    if (cycles == 30000) begin
      failCount++;
      wrapUp();
    end
  end

  task automatic wrapUp();
    if (failCount == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Mode only changes under reset, since it is a static setting.
  task automatic rst(input logic m);
    resetn <= 1'b0;
    syncMode <= m;
    rdEnable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdQ.delete();
    txQ.delete();
  endtask

  // Stream bytes into one end; valid stays up between bytes.
  task automatic sendRx(input logic [7:0] b0, input int n);
    for (int i = 0; i < n; i++) begin
      rxInData <= b0 + 8'(i);
      rxInValid <= 1'b1;
      do @(posedge clk_sys); while (rxInReady !== 1'b1);
    end
    rxInValid <= 1'b0;
  endtask

  task automatic sendWr(input logic [7:0] b0, input int n);
    for (int i = 0; i < n; i++) begin
      wrData <= b0 + 8'(i);
      wrValid <= 1'b1;
      do @(posedge clk_sys); while (wrReady !== 1'b1);
    end
    wrValid <= 1'b0;
  endtask

  // Wait for n bytes at one end and compare them with a rising count.
  task automatic checkQ(input bit rd, input logic [7:0] b0, input int n);
    while ((rd ? rdQ.size() : txQ.size()) < n) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      `CHK((rd ? rdQ[i] : txQ[i]), b0 + 8'(i))
    end
  endtask

  // Async writes with the user side stalled, then released.
  task automatic asyncWrite();
    txOutReady <= 1'b0;
    sendWr(8'h10, 4);
    repeat (40) @(posedge clk_sys);
    `CHK(txOutValid, 1'b1)
    `CHK(txQ.size(), 0)
    txOutReady <= 1'b1;
    checkQ(1'b0, 8'h10, 4);
    `CHK(lnk.txeN, 1'b0)
  endtask

  // Fill the receive buffer until it refuses, host stalled, then drain.
  task automatic asyncFill();
    sendRx(8'h80, 16);
    @(posedge clk_sys);
    `CHK(rxInReady, 1'b0)
    `CHK(lnk.rxfN, 1'b0)
    rdEnable <= 1'b1;
    checkQ(1'b1, 8'h80, 16);
    repeat (30) @(posedge clk_sys);
    `CHK(lnk.rxfN, 1'b1)
    `CHK(rdQ.size(), 16)
  endtask

  // Clocked mode: a write burst, then a queued read burst.
  task automatic syncBoth();
    txOutReady <= 1'b1;
    sendWr(8'ha0, 5);
    checkQ(1'b0, 8'ha0, 5);
    sendRx(8'hc0, 6);
    rdEnable <= 1'b1;
    checkQ(1'b1, 8'hc0, 6);
    repeat (40) @(posedge clk_sys);
    `CHK(lnk.rxfN, 1'b1)
    `CHK(lnk.txeN, 1'b0)
  endtask

  // Main sequence: async first, then a reset into clocked mode.
  initial begin
    rst(1'b0);
    asyncWrite();
    asyncFill();
    rst(1'b1);
    syncBoth();
    wrapUp();
  end
endmodule
